// ### hdl/led_anim_pkg.sv
// Constants, register map and types for the LED animation command block
package led_anim_pkg;

   // -----------------------------------------------------------------
   // Timing
   // -----------------------------------------------------------------
   localparam int unsigned CLK_HZ = 250_000_000;
   localparam int unsigned OSC_HZ = 2_400_000;
   localparam int unsigned OSC_CLK_RATIO = CLK_HZ / OSC_HZ;
   localparam int unsigned FRAME_OSC_CYCLES = (256 + 16) * 9;
   localparam int unsigned FRAME_CLK_CYCLES = FRAME_OSC_CYCLES * OSC_CLK_RATIO;
   localparam int unsigned PAGE_HOLD_UNIT = 8;
   localparam int unsigned SCROLL_UNIT = 32;
   localparam logic [3:0] SCROLL_POSITIONS = 4'h9;
   localparam logic [3:0] GRAY_PAGE_LIMIT = 4'h2;

   // -----------------------------------------------------------------
   // APB map: byte address is four times the index
   // -----------------------------------------------------------------
   localparam int unsigned ADDR_W = 12;
   localparam logic [7:0] IDX_MOVIE_START = 8'h11;
   localparam logic [7:0] IDX_LOOP_COUNT = 8'h13;
   localparam logic [7:0] IDX_PAGE_HOLD = 8'h14;
   localparam logic [7:0] IDX_FINAL_PAGE = 8'h15;
   localparam logic [7:0] IDX_SCROLL = 8'h20;
   localparam logic [7:0] IDX_SEQ_MODE = 8'h30;
   localparam logic [7:0] IDX_DEPTH = 8'h31;
   localparam logic [7:0] IDX_FADE = 8'h32;
   localparam logic [7:0] IDX_STATUS = 8'h40;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] RST_MOVIE_START = 8'h00;
   localparam logic [7:0] RST_LOOP_COUNT = 8'h00;
   localparam logic [7:0] RST_PAGE_HOLD = 8'h04;
   localparam logic [7:0] RST_FINAL_PAGE = 8'h00;
   localparam logic [7:0] RST_SCROLL = 8'h00;
   localparam logic [7:0] RST_SEQ_MODE = 8'h00;
   localparam logic [7:0] RST_DEPTH = 8'h00;
   localparam logic [7:0] RST_FADE = 8'h4a;

   // -----------------------------------------------------------------
   // Field positions and masks
   // -----------------------------------------------------------------
   localparam int unsigned MOVIE_RUN_BIT = 7;
   localparam int unsigned LOOP_ENDLESS_BIT = 3;
   localparam int unsigned SCROLL_ON_BIT = 7;
   localparam int unsigned SCROLL_RIGHT_BIT = 5;
   localparam int unsigned DEPTH_BIT = 7;
   localparam int unsigned FADE_ON_BIT = 7;
   localparam int unsigned GAMMA_BIT = 6;
   localparam int unsigned GLOBAL_BIT = 5;
   localparam int unsigned FADE_OUT_BIT = 4;
   localparam logic [7:0] MASK_MOVIE_START = 8'h8f;
   localparam logic [7:0] MASK_NIBBLE = 8'h0f;
   localparam logic [7:0] MASK_PAGE_HOLD = 8'h3f;
   localparam logic [7:0] MASK_SCROLL = 8'hbf;
   localparam logic [7:0] MASK_SEQ_MODE = 8'h01;
   localparam logic [7:0] MASK_DEPTH = 8'h80;

   typedef enum logic [1:0] {
      MOVIE_IDLE = 2'b00,
      MOVIE_PLAY = 2'b01,
      MOVIE_DONE = 2'b11
   } movie_state_t;

endpackage

// ### hdl/led_animation_command_set.sv
// LED animation command registers, movie sequencer, scroller and fade setup
// Summary of operation
// - Loop register low three bits pick one to eight movie passes; reset gives one.
// - Loop bit 3 plays forever; host stops it by writing zero to seven.
// - Undefined parameter values leave the function's setting unchanged.
// - Page hold register stores six-bit delay, reset value 04h.
// - Each movie page shows for (hold field plus one) times eight frames.
// - One frame is (256+16)*9 oscillator cycles; all frame delays use it.
// - Final page register holds four bits; gray depth allows only pages zero and one.
// - Scroll register: bit 7 on, bit 5 direction, bits 4:0 speed; reset zero.
// - Scroll steps every (speed field plus one) times 32 frames.
// - Scrolling is horizontal, one row, gray depth only.
// - Sequence mode bit 0 picks picture (0) or movie (1).
// - Depth bit 7 picks gray (0) or binary (1) pixels.
// - Fade register: bit 7 on, bit 6 gamma, bit 5 global; reset 4Ah.
// - Fade-out length is one or two base periods; extinguish and light are 1/4, 1/2, 1 or 2 base periods.
// - New fade settings take effect only at the start of a frame.
// - Base period comes from outside; per-dot fade void in binary depth.
// - Movie start register: bit 7 run enable, bits 3:0 first page; reset zero.
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
module led_animation_command_set
   import led_anim_pkg::*;
#(
   parameter int unsigned FRAME_CYCLES = FRAME_CLK_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [11:0] fadeBasePeriod,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   output logic frameTick,
   output logic moviePlaying,
   output logic movieFinished,
   output logic [3:0] moviePage,
   output logic binaryDepth,
   output logic scrollStep,
   output logic scrollRight,
   output logic [3:0] scrollOffset,
   output logic fadeEnable,
   output logic gammaCurve,
   output logic fadeGlobal,
   output logic fadePerDot,
   output logic [13:0] fadeOutFrames,
   output logic [13:0] extinguishFrames,
   output logic [13:0] lightFrames
);

   localparam int unsigned FRAME_W = $clog2(FRAME_CYCLES);

   // -----------------------------------------------------------------
   // Registers
   // -----------------------------------------------------------------
   logic [7:0] movieStart;
   logic [7:0] movie_loop_count;
   logic [7:0] movie_page_hold_delay;
   logic [7:0] movie_final_page;
   logic [7:0] scroll_control;
   logic [7:0] display_sequence_mode;
   logic [7:0] pixel_depth_select;
   logic [7:0] fade_control;
   logic [7:0] fadeActive;

   logic movie_run_enable;
   logic [3:0] movie_first_page;
   logic [3:0] loop_count_field;
   logic [5:0] page_hold_field;
   logic [3:0] final_page_field;
   logic scroll_on;
   logic scroll_toward_right;
   logic [4:0] scroll_step_rate;
   logic movie_or_picture_select;
   logic depth_select;

   assign movie_run_enable = movieStart[MOVIE_RUN_BIT];
   assign movie_first_page = movieStart[3:0];
   assign loop_count_field = movie_loop_count[3:0];
   assign page_hold_field = movie_page_hold_delay[5:0];
   assign final_page_field = movie_final_page[3:0];
   assign scroll_on = scroll_control[SCROLL_ON_BIT];
   assign scroll_toward_right = scroll_control[SCROLL_RIGHT_BIT];
   assign scroll_step_rate = scroll_control[4:0];
   assign movie_or_picture_select = display_sequence_mode[0];
   assign depth_select = pixel_depth_select[DEPTH_BIT];

   // -----------------------------------------------------------------
   // APB slave
   // -----------------------------------------------------------------
   logic [7:0] regIndex;
   logic addrAligned;
   logic addrKnown;
   logic writeTaken;
   logic [7:0] wrByte;
   logic pageValueOk;
   movie_state_t movieState;
   logic [7:0] statusWord;

   assign regIndex = paddr[9:2];
   assign addrAligned = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
   assign wrByte = pwdata[7:0];
   assign writeTaken = psel && penable && pready && pwrite && !pslverr;
   // Pages beyond one do not exist in gray depth
   assign pageValueOk = depth_select || (wrByte[3:0] < GRAY_PAGE_LIMIT);
   assign statusWord = {movieState == MOVIE_PLAY, movieState == MOVIE_DONE, 2'b00, moviePage};

   always_comb begin
      unique case (regIndex)
         IDX_MOVIE_START, IDX_LOOP_COUNT, IDX_PAGE_HOLD, IDX_FINAL_PAGE,
         IDX_SCROLL, IDX_SEQ_MODE, IDX_DEPTH, IDX_FADE, IDX_STATUS: begin
            addrKnown = addrAligned;
         end
         default: begin
            addrKnown = 1'b0;
         end
      endcase
   end

   // Zero wait: answer in the first access cycle
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable && !pready;
         pslverr <= psel && !penable && !pready && !addrKnown;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata <= '0;
      end else if (psel && !penable && !pwrite) begin
         unique case (regIndex)
            IDX_MOVIE_START: prdata <= {24'h000000, movieStart};
            IDX_LOOP_COUNT: prdata <= {24'h000000, movie_loop_count};
            IDX_PAGE_HOLD: prdata <= {24'h000000, movie_page_hold_delay};
            IDX_FINAL_PAGE: prdata <= {24'h000000, movie_final_page};
            IDX_SCROLL: prdata <= {24'h000000, scroll_control};
            IDX_SEQ_MODE: prdata <= {24'h000000, display_sequence_mode};
            IDX_DEPTH: prdata <= {24'h000000, pixel_depth_select};
            IDX_FADE: prdata <= {24'h000000, fade_control};
            IDX_STATUS: prdata <= {24'h000000, statusWord};
            default: prdata <= '0;
         endcase
      end
   end

   // -----------------------------------------------------------------
   // Command parameter registers
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         movieStart <= RST_MOVIE_START;
      end else if (writeTaken && regIndex == IDX_MOVIE_START && pageValueOk) begin
         movieStart <= wrByte & MASK_MOVIE_START;
      end
   end

   // Every nibble is a legal loop value, so no write is refused
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         movie_loop_count <= RST_LOOP_COUNT;
      end else if (writeTaken && regIndex == IDX_LOOP_COUNT) begin
         movie_loop_count <= wrByte & MASK_NIBBLE;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         movie_page_hold_delay <= RST_PAGE_HOLD;
      end else if (writeTaken && regIndex == IDX_PAGE_HOLD) begin
         movie_page_hold_delay <= wrByte & MASK_PAGE_HOLD;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         movie_final_page <= RST_FINAL_PAGE;
      end else if (writeTaken && regIndex == IDX_FINAL_PAGE && pageValueOk) begin
         movie_final_page <= wrByte & MASK_NIBBLE;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scroll_control <= RST_SCROLL;
      end else if (writeTaken && regIndex == IDX_SCROLL) begin
         scroll_control <= wrByte & MASK_SCROLL;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         display_sequence_mode <= RST_SEQ_MODE;
      end else if (writeTaken && regIndex == IDX_SEQ_MODE) begin
         display_sequence_mode <= wrByte & MASK_SEQ_MODE;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pixel_depth_select <= RST_DEPTH;
      end else if (writeTaken && regIndex == IDX_DEPTH) begin
         pixel_depth_select <= wrByte & MASK_DEPTH;
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fade_control <= RST_FADE;
      end else if (writeTaken && regIndex == IDX_FADE) begin
         fade_control <= wrByte;
      end
   end

   // -----------------------------------------------------------------
   // Frame timebase
   // -----------------------------------------------------------------
   logic [FRAME_W-1:0] frameCount;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         frameCount <= '0;
         frameTick <= 1'b0;
      end else if (frameCount == FRAME_W'(FRAME_CYCLES - 1)) begin
         frameCount <= '0;
         frameTick <= 1'b1;
      end else begin
         frameCount <= frameCount + 1'b1;
         frameTick <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Movie sequencer
   // -----------------------------------------------------------------
   logic movieRun;
   logic [9:0] holdCount;
   logic [9:0] holdLast;
   logic [2:0] passCount;
   logic holdDone;

   assign movieRun = movie_or_picture_select && movie_run_enable;
   assign holdLast = 10'((({4'h0, page_hold_field} + 10'd1) * PAGE_HOLD_UNIT) - 1);
   assign holdDone = frameTick && (holdCount == holdLast);

   // Host may lower the loop value mid-play, so compare with at-or-above
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         movieState <= MOVIE_IDLE;
         moviePage <= '0;
         holdCount <= '0;
         passCount <= '0;
      end else begin
         unique case (movieState)
            MOVIE_IDLE: begin
               if (movieRun) begin
                  movieState <= MOVIE_PLAY;
                  moviePage <= movie_first_page;
                  holdCount <= '0;
                  passCount <= '0;
               end
            end
            MOVIE_PLAY: begin
               if (!movieRun) begin
                  movieState <= MOVIE_IDLE;
               end else if (holdDone) begin
                  holdCount <= '0;
                  if (moviePage == final_page_field) begin
                     if (loop_count_field[LOOP_ENDLESS_BIT]
                         || passCount < loop_count_field[2:0]) begin
                        moviePage <= movie_first_page;
                        passCount <= passCount + 1'b1;
                     end else begin
                        movieState <= MOVIE_DONE;
                     end
                  end else begin
                     moviePage <= moviePage + 1'b1;
                  end
               end else if (frameTick) begin
                  holdCount <= holdCount + 1'b1;
               end
            end
            MOVIE_DONE: begin
               if (!movieRun) begin
                  movieState <= MOVIE_IDLE;
               end
            end
            default: begin
               movieState <= MOVIE_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         moviePlaying <= 1'b0;
         movieFinished <= 1'b0;
         binaryDepth <= 1'b0;
      end else begin
         moviePlaying <= movieState == MOVIE_PLAY;
         movieFinished <= movieState == MOVIE_DONE;
         binaryDepth <= depth_select;
      end
   end

   // -----------------------------------------------------------------
   // Horizontal scroll, single row
   // -----------------------------------------------------------------
   logic scrollActive;
   logic [10:0] scrollCount;
   logic [10:0] scrollLast;

   assign scrollActive = scroll_on && !depth_select;
   assign scrollLast = 11'((({6'h00, scroll_step_rate} + 11'd1) * SCROLL_UNIT) - 1);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         scrollCount <= '0;
         scrollOffset <= '0;
         scrollStep <= 1'b0;
         scrollRight <= 1'b0;
      end else begin
         scrollStep <= 1'b0;
         scrollRight <= scroll_toward_right;
         if (!scrollActive) begin
            scrollCount <= '0;
            scrollOffset <= '0;
         end else if (frameTick && scrollCount == scrollLast) begin
            scrollCount <= '0;
            scrollStep <= 1'b1;
            if (scroll_toward_right) begin
               scrollOffset <= (scrollOffset == SCROLL_POSITIONS - 4'h1) ? 4'h0
                                                                      : scrollOffset + 4'h1;
            end else begin
               scrollOffset <= (scrollOffset == 4'h0) ? SCROLL_POSITIONS - 4'h1
                                                     : scrollOffset - 4'h1;
            end
         end else if (frameTick) begin
            scrollCount <= scrollCount + 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // Fade setup
   // -----------------------------------------------------------------
   // Mid-frame changes would tear the fade ramp, so latch at frame start
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fadeActive <= RST_FADE;
      end else if (frameTick) begin
         fadeActive <= fade_control;
      end
   end

   function automatic logic [13:0] scaleBase(input logic [1:0] sel, input logic [11:0] base);
      logic [13:0] wide;
      wide = {2'b00, base};
      unique case (sel)
         2'b00: scaleBase = wide >> 2;
         2'b01: scaleBase = wide >> 1;
         2'b10: scaleBase = wide;
         2'b11: scaleBase = wide << 1;
      endcase
   endfunction

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         fadeEnable <= 1'b0;
         gammaCurve <= 1'b1;
         fadeGlobal <= 1'b0;
         fadePerDot <= 1'b0;
         fadeOutFrames <= '0;
         extinguishFrames <= '0;
         lightFrames <= '0;
      end else begin
         fadeEnable <= fadeActive[FADE_ON_BIT];
         gammaCurve <= fadeActive[GAMMA_BIT];
         fadeGlobal <= fadeActive[GLOBAL_BIT];
         fadePerDot <= fadeActive[FADE_ON_BIT] && !fadeActive[GLOBAL_BIT]
                       && !depth_select;
         fadeOutFrames <= scaleBase({1'b1, fadeActive[FADE_OUT_BIT]}, fadeBasePeriod);
         extinguishFrames <= scaleBase(fadeActive[3:2], fadeBasePeriod);
         lightFrames <= scaleBase(fadeActive[1:0], fadeBasePeriod);
      end
   end

endmodule

// ### verif/led_animation_command_set_checker.sv
// Port checker for the LED animation command block
`timescale 1ns/10ps
module led_animation_command_set_checker
   import led_anim_pkg::*;
#(
   parameter int unsigned FRAME_CYCLES = FRAME_CLK_CYCLES
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic frameTick,
   input wire logic moviePlaying,
   input wire logic movieFinished,
   input wire logic binaryDepth,
   input wire logic scrollStep,
   input wire logic [3:0] scrollOffset,
   input wire logic fadeEnable,
   input wire logic fadeGlobal,
   input wire logic fadePerDot
);
   // ---------------------------
   // Frame spacing
   // ---------------------------
   // Counts edges since the last pulse, so a slipped divider shows at once
   int unsigned tickGap;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tickGap <= 0;
      end else begin
         tickGap <= frameTick ? 1 : tickGap + 1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable && pready; endsequence
   property p_answer; s_setup |=> s_access; endproperty
   a_answer: assert property (p_answer) else $error("no ready in access cycle");
   property p_once; s_setup ##1 s_access |=> !pready; endproperty
   a_once: assert property (p_once) else $error("ready held too long");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err) else $error("error flag without ready");
   property p_tick; frameTick == (tickGap == FRAME_CYCLES); endproperty
   a_tick: assert property (p_tick) else $error("frame pulse spacing wrong");
   property p_fade;
      $changed(fadeEnable) || $changed(fadeGlobal) |-> $past(frameTick) || $past(frameTick, 2);
   endproperty
   a_fade: assert property (p_fade) else $error("fade setting changed mid frame");
   property p_perdot; fadePerDot |-> fadeEnable && !fadeGlobal; endproperty
   a_perdot: assert property (p_perdot) else $error("per dot fade wrongly on");
   property p_excl; moviePlaying |-> !movieFinished; endproperty
   a_excl: assert property (p_excl) else $error("playing and finished together");
   property p_scroll; scrollStep |-> !binaryDepth; endproperty
   a_scroll: assert property (p_scroll) else $error("scroll step in binary depth");
   property p_range; scrollOffset <= 4'h8; endproperty
   a_range: assert property (p_range) else $error("scroll offset out of row");
endmodule

bind led_animation_command_set led_animation_command_set_checker #(
   .FRAME_CYCLES(FRAME_CYCLES)
) u_chk (
   .clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .pready(pready),
   .pslverr(pslverr), .frameTick(frameTick), .moviePlaying(moviePlaying),
   .movieFinished(movieFinished), .binaryDepth(binaryDepth), .scrollStep(scrollStep),
   .scrollOffset(scrollOffset), .fadeEnable(fadeEnable), .fadeGlobal(fadeGlobal),
   .fadePerDot(fadePerDot)
);

// ### verif/apb_host_model.sv
// Host model issuing command transfers over APB
`timescale 1ns/10ps
module apb_host_model
   import led_anim_pkg::*;
(
   input wire logic clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr
);
   initial begin
      {psel, penable, pwrite} = 3'b000;
      paddr = '0;
      pwdata = '0;
   end
   // ---------------------------
   // One transfer
   // ---------------------------
   // Command code rides as the address, its parameter as the data
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] v,
         output logic [7:0] rd, output logic err, output logic ok);
      int n;
      @(posedge clk);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, v};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 64);
      ok = (pready === 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      {psel, penable} <= 2'b00;
      // Released data must not keep looking valid
      pwdata <= ~pwdata;
   endtask
endmodule

// ### verif/led_animation_command_set_tb.sv
// Self-checking bench for the LED animation command block
`timescale 1ns/10ps
`define CK(nm, e, g) begin totalChecks++; if ((g) !== (e)) begin fails++; \
   $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module led_animation_command_set_tb
   import led_anim_pkg::*;
;
   localparam int unsigned FC = 8;
   localparam logic [13:0] BASE = 14'h010;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, frameTick, moviePlaying, movieFinished;
   logic binaryDepth, scrollStep, scrollRight, fadeEnable, gammaCurve, fadeGlobal, fadePerDot;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] moviePage, scrollOffset;
   logic [13:0] fadeOutFrames, extinguishFrames, lightFrames;
   logic [41:0] lens;
   assign lens = {fadeOutFrames, extinguishFrames, lightFrames};
   logic [7:0] rd;
   logic err, ok;
   logic [7:0] idxTab [8] = '{IDX_MOVIE_START, IDX_LOOP_COUNT, IDX_PAGE_HOLD, IDX_FINAL_PAGE,
      IDX_SCROLL, IDX_SEQ_MODE, IDX_DEPTH, IDX_FADE};
   logic [7:0] rstTab [8] = '{RST_MOVIE_START, RST_LOOP_COUNT, RST_PAGE_HOLD, RST_FINAL_PAGE,
      RST_SCROLL, RST_SEQ_MODE, RST_DEPTH, RST_FADE};
   int fails = 0;
   int totalChecks = 0;
   int cyc = 0;
   int lastStep = 0;
   int chg, gap, o;
   always #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;
   led_animation_command_set #(.FRAME_CYCLES(FC)) u_dut (.clk, .resetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .fadeBasePeriod(BASE[11:0]), .pready, .prdata, .pslverr,
      .frameTick, .moviePlaying, .movieFinished, .moviePage, .binaryDepth, .scrollStep,
      .scrollRight, .scrollOffset, .fadeEnable, .gammaCurve, .fadeGlobal, .fadePerDot,
      .fadeOutFrames, .extinguishFrames, .lightFrames);
   apb_host_model u_host (.clk, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr);
   // ---------------------------
   // Tasks
   // ---------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", totalChecks, fails);
      if (fails == 0 && totalChecks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] v);
      u_host.xfer(w, a, v, rd, err, ok);
      if (!ok) begin
         fails++;
         complete_run();
      end
   endtask
   task automatic wr(input logic [7:0] i, input logic [7:0] v);
      acc(1'b1, {2'b00, i, 2'b00}, v);
   endtask
   task automatic rdc(input logic [7:0] i, input logic [7:0] e);
      acc(1'b0, {2'b00, i, 2'b00}, 8'h00);
      `CK("readback", e, rd)
   endtask
   task automatic ticks(input int n);
      for (int t = 0; t < 1000 && n > 0; t++) begin
         @(posedge clk);
         if (frameTick === 1'b1) n--;
      end
      `CK("frameTick", 0, n)
      if (n > 0) complete_run();
      @(posedge clk);
   endtask
   task automatic stepWait();
      int t;
      t = 0;
      do begin
         @(posedge clk);
         t++;
      end while (scrollStep !== 1'b1 && t < 1200);
      `CK("scrollStep", 1'b1, scrollStep)
      if (scrollStep !== 1'b1) complete_run();
      gap = cyc - lastStep;
      lastStep = cyc;
      repeat (2) @(posedge clk);
   endtask
   // Counts page changes while playing; gap is the second hold in cycles
   task automatic movie(input logic [7:0] loop, input int lim);
      int t0;
      logic [3:0] last;
      wr(IDX_MOVIE_START, 8'h00);
      wr(IDX_LOOP_COUNT, loop);
      wr(IDX_MOVIE_START, 8'h80);
      @(posedge clk);
      // Every run starts on page zero; the page left by a prior run is stale
      last = 4'h0;
      {chg, gap, t0} = '0;
      for (int t = 0; t < lim && movieFinished !== 1'b1; t++) begin
         @(posedge clk);
         if (moviePlaying === 1'b1 && moviePage !== last) begin
            chg++;
            if (chg == 2) gap = cyc - t0;
            t0 = cyc;
            last = moviePage;
         end
      end
   endtask
   // ---------------------------
   // Main sequence
   // ---------------------------
   initial begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      `CK("gamma", 1'b1, gammaCurve)
      for (int k = 0; k < 8; k++) begin
         rdc(idxTab[k], rstTab[k]);
      end
      acc(1'b0, 12'h0fc, 8'h00);
      `CK("unmapped", 1'b1, err)
      acc(1'b1, 12'h051, 8'h00);
      `CK("misaligned", 1'b1, err)
      rdc(IDX_PAGE_HOLD, RST_PAGE_HOLD);
      wr(IDX_PAGE_HOLD, 8'hff);
      rdc(IDX_PAGE_HOLD, 8'h3f);
      wr(IDX_SCROLL, 8'h5f);
      rdc(IDX_SCROLL, 8'h1f);
      wr(IDX_PAGE_HOLD, 8'h00);
      wr(IDX_FINAL_PAGE, 8'h01);
      wr(IDX_FINAL_PAGE, 8'h05);
      rdc(IDX_FINAL_PAGE, 8'h01);
      wr(IDX_FADE, 8'hff);
      ticks(2);
      `CK("fadeFlags", 4'he, {fadeEnable, gammaCurve, fadeGlobal, fadePerDot})
      `CK("lengths", {BASE << 1, BASE << 1, BASE << 1}, lens)
      wr(IDX_FADE, 8'h85);
      ticks(2);
      `CK("fadeFlags", 4'h9, {fadeEnable, gammaCurve, fadeGlobal, fadePerDot})
      `CK("lengths", {BASE, BASE >> 1, BASE >> 1}, lens)
      wr(IDX_DEPTH, 8'h80);
      ticks(2);
      `CK("perDot", 2'b10, {binaryDepth, fadePerDot})
      wr(IDX_DEPTH, 8'h00);
      wr(IDX_FADE, RST_FADE);
      wr(IDX_SEQ_MODE, 8'h01);
      movie(8'h00, 1000);
      `CK("passes", 1, chg)
      `CK("done", 6'h11, {moviePlaying, movieFinished, moviePage})
      if (movieFinished !== 1'b1) complete_run();
      movie(8'h07, 3000);
      `CK("passes", 15, chg)
      `CK("pageHold", PAGE_HOLD_UNIT * FC, gap)
      if (movieFinished !== 1'b1) complete_run();
      movie(8'h08, 800);
      `CK("endless", 2'b10, {moviePlaying, movieFinished})
      wr(IDX_LOOP_COUNT, 8'h00);
      for (int t = 0; t < 400 && movieFinished !== 1'b1; t++) @(posedge clk);
      `CK("stopped", 1'b1, movieFinished)
      if (movieFinished !== 1'b1) complete_run();
      wr(IDX_MOVIE_START, 8'h00);
      wr(IDX_SCROLL, 8'ha0);
      stepWait();
      o = scrollOffset;
      stepWait();
      `CK("scrollGap", SCROLL_UNIT * FC, gap)
      `CK("right", {1'b1, 4'((o + 1) % 9)}, {scrollRight, scrollOffset})
      wr(IDX_SCROLL, 8'h80);
      o = scrollOffset;
      stepWait();
      `CK("left", {1'b0, 4'((o + 8) % 9)}, {scrollRight, scrollOffset})
      wr(IDX_DEPTH, 8'h80);
      repeat (3) @(posedge clk);
      `CK("offReset", 4'h0, scrollOffset)
      o = 0;
      repeat (600) begin
         @(posedge clk);
         if (scrollStep !== 1'b0) o++;
      end
      `CK("noStep", 0, o)
      complete_run();
   end
endmodule
